// ---- hw/host_fifo_params.svh ----
// offsets, field positions and reset values of the host fifo ports
// assumes byte addressing on an 8-bit host address, 32-bit words
`ifndef HOST_FIFO_PARAMS_SVH
`define HOST_FIFO_PARAMS_SVH

// aliased data windows, selected by the two address msbs
`define ALIAS_SEL_MSB 7
`define ALIAS_SEL_LSB 6
`define ALIAS_RX_DATA 2'h0
`define ALIAS_TX_DATA 2'h1
// single-word ports
`define OFS_RX_STAT_POP 8'h80
`define OFS_RX_STAT_PEEK 8'h84
`define OFS_TX_STAT_POP 8'h88
`define OFS_TX_STAT_PEEK 8'h8c
`define OFS_STATUS 8'h90
`define OFS_CONTROL 8'h94
`define OFS_CONFIG 8'h98
// status word fields
`define BIT_TX_OVERFLOW 0
`define BIT_RX_UNDERRUN 1
`define BIT_RX_STAT_AVAIL 2
`define BIT_TX_ROOM 3
`define FLD_RX_LEVEL_LSB 8
`define FLD_TX_LEVEL_LSB 16
// control word fields
`define BIT_FLUSH_TX 0
`define BIT_FLUSH_RX 1
`define BIT_FLUSH_STAT 2
// config word fields
`define FLD_KEPT_LSB 0
`define FLD_KEPT_MSB 7
`define FLD_PLAIN_LSB 8
`define FLD_PLAIN_MSB 15
// reset values
`define RST_KEPT 8'h00
`define RST_PLAIN 8'h00
`define RST_TX_ROOM 1'b1
`define WORD_ZERO 32'h0000_0000

`endif

// ---- hw/host_fifo_pkg.sv ----
// types shared by the host fifo port logic
// assumes 32-bit host data words
package host_fifo_pkg;
   typedef logic [31:0] word_t;
   typedef logic [7:0] level_t;
   typedef enum {
      SEL_NONE,
      SEL_RX_DATA,
      SEL_TX_DATA,
      SEL_RX_STAT_POP,
      SEL_RX_STAT_PEEK,
      SEL_TX_STAT_POP,
      SEL_TX_STAT_PEEK,
      SEL_STATUS,
      SEL_CONTROL,
      SEL_CONFIG
   } port_sel_t;
endpackage : host_fifo_pkg

// ---- hw/fifo_queue.sv ----
// synchronous queue with a run-time capacity limit
// assumes push and pop come from logic on the same clock
`timescale 1ns/100ps
module fifo_queue #(
   parameter int WIDTH = 32,
   parameter int ADDR_W = 6
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   input wire logic flush,
   // capacity, zero or above depth means full depth
   input wire logic [ADDR_W:0] limit,
   // fill side
   input wire logic push,
   input wire logic [WIDTH-1:0] pushData,
   output logic pushReady,
   // drain side
   input wire logic pop,
   output logic [WIDTH-1:0] popData,
   output logic popValid,
   output logic [ADDR_W:0] count
);
   localparam logic [ADDR_W:0] DEPTH = (ADDR_W+1)'(1 << ADDR_W);

   logic [WIDTH-1:0] mem [0:(1 << ADDR_W)-1];
   logic [ADDR_W-1:0] wrPtr_reg;
   logic [ADDR_W-1:0] rdPtr_reg;
   logic [ADDR_W:0] count_reg;
   logic [ADDR_W:0] capacity;
   logic doPush;
   logic doPop;

   assign capacity = (limit == '0 || limit > DEPTH) ? DEPTH : limit;
   assign pushReady = count_reg < capacity;
   assign popValid = count_reg != '0;
   assign doPush = push && pushReady;
   assign doPop = pop && popValid;
   assign popData = mem[rdPtr_reg];
   assign count = count_reg;

   always_ff @(posedge clock) begin
      if (doPush) begin
         mem[wrPtr_reg] <= pushData;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
      end else if (flush) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (doPush) begin
            wrPtr_reg <= wrPtr_reg + 1'b1;
         end
         if (doPop) begin
            rdPtr_reg <= rdPtr_reg + 1'b1;
         end
         if (doPush && !doPop) begin
            count_reg <= count_reg + 1'b1;
         end else if (doPop && !doPush) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule : fifo_queue

// ---- hw/host_fifo_port_access.sv ----
// host access to the receive and transmit queues, with status,
// control and config words showing the register access attributes
// assumes one-cycle host strobes from logic on the same clock
`timescale 1ns/100ps
`include "host_fifo_params.svh"
module host_fifo_port_access
   import host_fifo_pkg::*;
#(
   parameter int DATA_AW = 6,
   parameter int STAT_AW = 4
) (
   // clock and resets
   input wire logic clock,
   input wire logic reset,
   input wire logic softReset,
   // host access
   input wire logic hostCs,
   input wire logic hostRd,
   input wire logic hostWr,
   input wire logic [7:0] hostAddr,
   input wire word_t hostWrData,
   output word_t hostRdData,
   output logic hostRdValid,
   // configured capacities
   input wire logic [DATA_AW:0] rxDataLimit,
   input wire logic [STAT_AW:0] rxStatLimit,
   input wire logic [DATA_AW:0] txDataLimit,
   // receive side fill
   input wire logic rxDataPush,
   input wire word_t rxDataIn,
   output logic rxDataReady,
   input wire logic rxStatPush,
   input wire word_t rxStatIn,
   output logic rxStatReady,
   // transmit side
   output word_t txDataOut,
   output logic txDataValid,
   input wire logic txDataTake,
   input wire logic txStatPush,
   input wire word_t txStatIn,
   output logic txStatReady,
   // config word fields
   output level_t cfgKept,
   output level_t cfgPlain
);
   port_sel_t sel;
   logic rdStrobe;
   logic wrStrobe;
   word_t readValue;

   logic rxDataPop;
   logic rxStatPop;
   logic txStatPop;
   logic txDataPush;
   logic statusRead;

   word_t rxDataHead;
   word_t rxStatHead;
   word_t txStatHead;
   logic rxDataValid;
   logic rxStatValid;
   logic txStatValid;
   logic txDataRoom;
   logic [DATA_AW:0] rxDataCount;
   logic [DATA_AW:0] txDataCount;

   logic txOverflow_reg;
   logic txOverflow_next;
   logic rxUnderrun_reg;
   logic rxUnderrun_next;
   logic rxStatAvail_reg;
   logic rxStatAvail_next;
   logic txRoom_reg;
   logic txRoom_next;
   logic flushTx_reg;
   logic flushRx_reg;
   logic flushStat_reg;
   level_t cfgKept_reg;
   level_t cfgPlain_reg;
   word_t hostRdData_reg;
   logic hostRdValid_reg;

   // a read and a write together count as a read only
   assign rdStrobe = hostCs && hostRd;
   assign wrStrobe = hostCs && hostWr && !hostRd;

   always_comb begin
      sel = SEL_NONE;
      case (hostAddr[`ALIAS_SEL_MSB:`ALIAS_SEL_LSB])
         `ALIAS_RX_DATA: begin
            sel = SEL_RX_DATA;
         end
         `ALIAS_TX_DATA: begin
            sel = SEL_TX_DATA;
         end
         default: begin
            case ({hostAddr[7:2], 2'b00})
               `OFS_RX_STAT_POP: sel = SEL_RX_STAT_POP;
               `OFS_RX_STAT_PEEK: sel = SEL_RX_STAT_PEEK;
               `OFS_TX_STAT_POP: sel = SEL_TX_STAT_POP;
               `OFS_TX_STAT_PEEK: sel = SEL_TX_STAT_PEEK;
               `OFS_STATUS: sel = SEL_STATUS;
               `OFS_CONTROL: sel = SEL_CONTROL;
               `OFS_CONFIG: sel = SEL_CONFIG;
               default: sel = SEL_NONE;
            endcase
         end
      endcase
   end

   // one pop per read strobe, peeks never pop
   assign rxDataPop = rdStrobe && sel == SEL_RX_DATA;
   assign rxStatPop = rdStrobe && sel == SEL_RX_STAT_POP;
   assign txStatPop = rdStrobe && sel == SEL_TX_STAT_POP;
   assign statusRead = rdStrobe && sel == SEL_STATUS;
   assign txDataPush = wrStrobe && sel == SEL_TX_DATA;

   // receive queues have no host write path
   fifo_queue #(.WIDTH(32), .ADDR_W(DATA_AW)) rxDataQueue (
      .clock(clock),
      .reset(reset),
      .flush(softReset || flushRx_reg),
      .limit(rxDataLimit),
      .push(rxDataPush),
      .pushData(rxDataIn),
      .pushReady(rxDataReady),
      .pop(rxDataPop),
      .popData(rxDataHead),
      .popValid(rxDataValid),
      .count(rxDataCount)
   );

   fifo_queue #(.WIDTH(32), .ADDR_W(STAT_AW)) rxStatQueue (
      .clock(clock),
      .reset(reset),
      .flush(softReset || flushStat_reg),
      .limit(rxStatLimit),
      .push(rxStatPush),
      .pushData(rxStatIn),
      .pushReady(rxStatReady),
      .pop(rxStatPop),
      .popData(rxStatHead),
      .popValid(rxStatValid),
      .count()
   );

   fifo_queue #(.WIDTH(32), .ADDR_W(DATA_AW)) txDataQueue (
      .clock(clock),
      .reset(reset),
      .flush(softReset || flushTx_reg),
      .limit(txDataLimit),
      .push(txDataPush),
      .pushData(hostWrData),
      .pushReady(txDataRoom),
      .pop(txDataTake),
      .popData(txDataOut),
      .popValid(txDataValid),
      .count(txDataCount)
   );

   // transmit status capacity is fixed at full depth
   fifo_queue #(.WIDTH(32), .ADDR_W(STAT_AW)) txStatQueue (
      .clock(clock),
      .reset(reset),
      .flush(softReset || flushStat_reg),
      .limit('0),
      .push(txStatPush),
      .pushData(txStatIn),
      .pushReady(txStatReady),
      .pop(txStatPop),
      .popData(txStatHead),
      .popValid(txStatValid),
      .count()
   );

   // read mux; empty queues and unmapped words read as zero
   always_comb begin
      readValue = `WORD_ZERO;
      case (sel)
         SEL_RX_DATA: readValue = rxDataValid ? rxDataHead : `WORD_ZERO;
         SEL_RX_STAT_POP: readValue = rxStatValid ? rxStatHead : `WORD_ZERO;
         SEL_RX_STAT_PEEK: readValue = rxStatValid ? rxStatHead : `WORD_ZERO;
         SEL_TX_STAT_POP: readValue = txStatValid ? txStatHead : `WORD_ZERO;
         SEL_TX_STAT_PEEK: readValue = txStatValid ? txStatHead : `WORD_ZERO;
         SEL_TX_DATA: readValue = `WORD_ZERO;
         SEL_CONTROL: readValue = `WORD_ZERO;
         SEL_STATUS: begin
            readValue[`BIT_TX_OVERFLOW] = txOverflow_reg;
            readValue[`BIT_RX_UNDERRUN] = rxUnderrun_reg;
            readValue[`BIT_RX_STAT_AVAIL] = rxStatAvail_reg;
            readValue[`BIT_TX_ROOM] = txRoom_reg;
            readValue[`FLD_RX_LEVEL_LSB +: 8] = 8'(rxDataCount);
            readValue[`FLD_TX_LEVEL_LSB +: 8] = 8'(txDataCount);
         end
         SEL_CONFIG: begin
            readValue[`FLD_KEPT_MSB:`FLD_KEPT_LSB] = cfgKept_reg;
            readValue[`FLD_PLAIN_MSB:`FLD_PLAIN_LSB] = cfgPlain_reg;
         end
         default: readValue = `WORD_ZERO;
      endcase
   end

   // status word next values; a new event beats a same-cycle clear
   always_comb begin
      txOverflow_next = (txDataPush && !txDataRoom) ||
         (txOverflow_reg && !(wrStrobe && sel == SEL_STATUS &&
         hostWrData[`BIT_TX_OVERFLOW]));
      // cleared by reading the status word
      rxUnderrun_next = ((rxDataPop && !rxDataValid) ||
         (rxStatPop && !rxStatValid)) || (rxUnderrun_reg && !statusRead);
      rxStatAvail_next = rxStatValid || (rxStatAvail_reg && !statusRead);
      // latch low until read, read releases to current state
      txRoom_next = statusRead ? txDataRoom : (txRoom_reg && txDataRoom);
   end

   // writes to the status word touch only the clearable bit
   // defaults on system or soft reset
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         txOverflow_reg <= 1'b0;
         rxUnderrun_reg <= 1'b0;
         rxStatAvail_reg <= 1'b0;
         txRoom_reg <= `RST_TX_ROOM;
      end else if (softReset) begin
         txOverflow_reg <= 1'b0;
         rxUnderrun_reg <= 1'b0;
         rxStatAvail_reg <= 1'b0;
         txRoom_reg <= `RST_TX_ROOM;
      end else begin
         txOverflow_reg <= txOverflow_next;
         rxUnderrun_reg <= rxUnderrun_next;
         rxStatAvail_reg <= rxStatAvail_next;
         txRoom_reg <= txRoom_next;
      end
   end

   // self-clearing flush strobes, high for one cycle per written one
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         flushTx_reg <= 1'b0;
         flushRx_reg <= 1'b0;
         flushStat_reg <= 1'b0;
      end else if (softReset) begin
         flushTx_reg <= 1'b0;
         flushRx_reg <= 1'b0;
         flushStat_reg <= 1'b0;
      end else if (wrStrobe && sel == SEL_CONTROL) begin
         flushTx_reg <= hostWrData[`BIT_FLUSH_TX];
         flushRx_reg <= hostWrData[`BIT_FLUSH_RX];
         flushStat_reg <= hostWrData[`BIT_FLUSH_STAT];
      end else begin
         flushTx_reg <= 1'b0;
         flushRx_reg <= 1'b0;
         flushStat_reg <= 1'b0;
      end
   end

   // kept field answers only the system reset
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         cfgKept_reg <= `RST_KEPT;
      end else if (wrStrobe && !softReset && sel == SEL_CONFIG) begin
         cfgKept_reg <= hostWrData[`FLD_KEPT_MSB:`FLD_KEPT_LSB];
      end
   end

   // ordinary config field follows both resets
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         cfgPlain_reg <= `RST_PLAIN;
      end else if (softReset) begin
         cfgPlain_reg <= `RST_PLAIN;
      end else if (wrStrobe && sel == SEL_CONFIG) begin
         cfgPlain_reg <= hostWrData[`FLD_PLAIN_MSB:`FLD_PLAIN_LSB];
      end
   end

   // read answer one cycle after the strobe, value sampled pre-pop
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         hostRdData_reg <= `WORD_ZERO;
         hostRdValid_reg <= 1'b0;
      end else if (softReset) begin
         hostRdData_reg <= `WORD_ZERO;
         hostRdValid_reg <= 1'b0;
      end else begin
         hostRdValid_reg <= rdStrobe;
         if (rdStrobe) begin
            hostRdData_reg <= readValue;
         end
      end
   end

   assign hostRdData = hostRdData_reg;
   assign hostRdValid = hostRdValid_reg;
   assign cfgKept = cfgKept_reg;
   assign cfgPlain = cfgPlain_reg;
endmodule : host_fifo_port_access

// ---- tb/host_fifo_port_access_asserts.sv ----
// concurrent checks on the host fifo port block
// assumes one-cycle host strobes and a registered read answer
`timescale 1ns/100ps
`include "host_fifo_params.svh"
module host_fifo_port_access_asserts
   import host_fifo_pkg::*;
#(
   parameter int DATA_AW = 6,
   parameter int STAT_AW = 4
) (
   // clock and resets
   input wire logic clock,
   input wire logic reset,
   input wire logic softReset,
   // host access
   input wire logic hostCs,
   input wire logic hostRd,
   input wire logic hostWr,
   input wire logic [7:0] hostAddr,
   input wire word_t hostWrData,
   input wire word_t hostRdData,
   input wire logic hostRdValid,
   // capacities
   input wire logic [DATA_AW:0] rxDataLimit,
   input wire logic [STAT_AW:0] rxStatLimit,
   input wire logic [DATA_AW:0] txDataLimit,
   // fill and drain sides
   input wire logic rxDataPush,
   input wire word_t rxDataIn,
   input wire logic rxDataReady,
   input wire logic rxStatPush,
   input wire word_t rxStatIn,
   input wire logic rxStatReady,
   input wire word_t txDataOut,
   input wire logic txDataValid,
   input wire logic txDataTake,
   input wire logic txStatPush,
   input wire word_t txStatIn,
   input wire logic txStatReady,
   // config fields
   input wire level_t cfgKept,
   input wire level_t cfgPlain
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   logic rdTake;
   logic wrTake;
   assign rdTake = hostCs && hostRd && !softReset;
   assign wrTake = hostCs && hostWr && !hostRd && !softReset;

   a_read_answers: assert property (rdTake |=> hostRdValid)
      else $error("read not answered next cycle");
   a_valid_cause: assert property (hostRdValid |-> $past(rdTake))
      else $error("answer without a read");
   a_wo_zero: assert property (
      rdTake && hostAddr == `OFS_CONTROL |=> hostRdData == `WORD_ZERO)
      else $error("control read not zero");
   a_tx_read_zero: assert property (
      rdTake && hostAddr[7:6] == `ALIAS_TX_DATA && !txDataTake
      |=> hostRdData == `WORD_ZERO && $stable(txDataValid))
      else $error("tx data read visible");
   a_tx_append: assert property (
      wrTake && hostAddr[7:6] == `ALIAS_TX_DATA && !txDataValid
      |=> txDataValid && txDataOut == $past(hostWrData))
      else $error("tx write not appended");
   a_kept_soft: assert property (softReset |=> $stable(cfgKept))
      else $error("kept field lost on soft reset");
   a_soft_defaults: assert property (
      softReset |=> cfgPlain == `RST_PLAIN && !txDataValid && !hostRdValid)
      else $error("soft reset default missing");
   a_soft_ready: assert property (
      softReset |=> rxDataReady && rxStatReady && txStatReady)
      else $error("queue not empty after soft reset");

   cover property (rdTake && hostAddr == `OFS_RX_STAT_PEEK);
   cover property (rdTake && hostAddr == `OFS_TX_STAT_POP);
   cover property (txDataTake && txDataValid);
   cover property (softReset);
endmodule : host_fifo_port_access_asserts

bind host_fifo_port_access host_fifo_port_access_asserts #(
   .DATA_AW(DATA_AW), .STAT_AW(STAT_AW)
) host_fifo_port_access_asserts_i (
   .clock(clock), .reset(reset), .softReset(softReset),
   .hostCs(hostCs), .hostRd(hostRd), .hostWr(hostWr),
   .hostAddr(hostAddr), .hostWrData(hostWrData),
   .hostRdData(hostRdData), .hostRdValid(hostRdValid),
   .rxDataLimit(rxDataLimit), .rxStatLimit(rxStatLimit),
   .txDataLimit(txDataLimit), .rxDataPush(rxDataPush),
   .rxDataIn(rxDataIn), .rxDataReady(rxDataReady),
   .rxStatPush(rxStatPush), .rxStatIn(rxStatIn),
   .rxStatReady(rxStatReady), .txDataOut(txDataOut),
   .txDataValid(txDataValid), .txDataTake(txDataTake),
   .txStatPush(txStatPush), .txStatIn(txStatIn),
   .txStatReady(txStatReady), .cfgKept(cfgKept), .cfgPlain(cfgPlain)
);

// ---- tb/host_model.sv ----
// host processor on the parallel bus, one access per task call
// assumes the block answers a read in the cycle after the strobe
`timescale 1ns/100ps
module host_model
   import host_fifo_pkg::*;
(
   // clock
   input wire logic clock,
   // bus towards the block
   output logic hostCs,
   output logic hostRd,
   output logic hostWr,
   output logic [7:0] hostAddr,
   output word_t hostWrData,
   // answer
   input wire word_t hostRdData,
   input wire logic hostRdValid
);
   initial begin
      hostCs = 1'b0;
      hostRd = 1'b0;
      hostWr = 1'b0;
      hostAddr = 8'hff;
      hostWrData = 32'hffff_ffff;
   end

   task automatic hostRead(input logic [7:0] a, output word_t d,
                           output logic v);
      @(negedge clock);
      hostCs = 1'b1;
      hostRd = 1'b1;
      hostAddr = a;
      @(negedge clock);
      d = hostRdData;
      v = hostRdValid;
      hostCs = 1'b0;
      hostRd = 1'b0;
      // released address shows no stale value
      hostAddr = ~a;
   endtask : hostRead

   task automatic hostWrite(input logic [7:0] a, input word_t d);
      @(negedge clock);
      hostCs = 1'b1;
      hostWr = 1'b1;
      hostAddr = a;
      hostWrData = d;
      @(negedge clock);
      hostCs = 1'b0;
      hostWr = 1'b0;
      hostAddr = ~a;
      hostWrData = ~d;
   endtask : hostWrite
endmodule : host_model

// ---- tb/testbench.sv ----
// self-checking bench for the host fifo port block
// assumes host_model drives the host bus, the bench the fill sides
`timescale 1ns/100ps
`include "host_fifo_params.svh"
module testbench
   import host_fifo_pkg::*;
;
   logic clock, reset, softReset, hostCs, hostRd, hostWr, hostRdValid;
   logic [7:0] hostAddr;
   word_t hostWrData, hostRdData, rxDataIn, rxStatIn, txStatIn, txDataOut;
   logic [6:0] rxDataLimit, txDataLimit;
   logic [4:0] rxStatLimit;
   logic rxDataPush, rxDataReady, rxStatPush, rxStatReady, txDataValid;
   logic txDataTake, txStatPush, txStatReady;
   level_t cfgKept, cfgPlain;
   int fail_count = 0;
   int comparisons = 0;
   localparam word_t ALL = 32'hffff_ffff;
   localparam word_t SMASK = 32'h00ff_ff0b;

   host_fifo_port_access host_fifo_port_access_i (
      .clock(clock), .reset(reset), .softReset(softReset),
      .hostCs(hostCs), .hostRd(hostRd), .hostWr(hostWr),
      .hostAddr(hostAddr), .hostWrData(hostWrData),
      .hostRdData(hostRdData), .hostRdValid(hostRdValid),
      .rxDataLimit(rxDataLimit), .rxStatLimit(rxStatLimit),
      .txDataLimit(txDataLimit), .rxDataPush(rxDataPush),
      .rxDataIn(rxDataIn), .rxDataReady(rxDataReady),
      .rxStatPush(rxStatPush), .rxStatIn(rxStatIn),
      .rxStatReady(rxStatReady), .txDataOut(txDataOut),
      .txDataValid(txDataValid), .txDataTake(txDataTake),
      .txStatPush(txStatPush), .txStatIn(txStatIn),
      .txStatReady(txStatReady), .cfgKept(cfgKept), .cfgPlain(cfgPlain));
   host_model host_model_i (
      .clock(clock), .hostCs(hostCs), .hostRd(hostRd), .hostWr(hostWr),
      .hostAddr(hostAddr), .hostWrData(hostWrData),
      .hostRdData(hostRdData), .hostRdValid(hostRdValid));

   always #50 clock = ~clock;

   task automatic check_word(input word_t got, input word_t exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t word %h expected %h", $time, got, exp);
      end
   endtask : check_word

   task automatic check_flag(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
      end
   endtask : check_flag

   task automatic rd(input logic [7:0] a, input word_t exp, input word_t m);
      word_t d;
      logic v;
      host_model_i.hostRead(a, d, v);
      check_flag(v, 1'b1);
      check_word(d & m, exp);
   endtask : rd

   task automatic push(input int which, input word_t d);
      @(negedge clock);
      rxDataIn = d;
      rxStatIn = d;
      txStatIn = d;
      rxDataPush = (which == 0);
      rxStatPush = (which == 1);
      txStatPush = (which == 2);
      @(negedge clock);
      {rxDataPush, rxStatPush, txStatPush} = 3'h0;
      {rxDataIn, rxStatIn, txStatIn} = {3{~d}};
   endtask : push

   task automatic s_stat(input bit tx);
      logic [7:0] b;
      b = tx ? `OFS_TX_STAT_POP : `OFS_RX_STAT_POP;
      push(tx ? 2 : 1, 32'h0000_0a01);
      push(tx ? 2 : 1, 32'h0000_0a02);
      rd(b + 8'h04, 32'h0000_0a01, ALL);
      rd(b + 8'h04, 32'h0000_0a01, ALL);
      rd(b, 32'h0000_0a01, ALL);
      rd(b + 8'h04, 32'h0000_0a02, ALL);
      rd(b, 32'h0000_0a02, ALL);
      rd(b, `WORD_ZERO, ALL);
   endtask : s_stat

   task automatic s_rx_data();
      push(0, 32'h0000_0011);
      push(0, 32'h0000_0022);
      push(0, 32'h0000_0033);
      host_model_i.hostWrite(8'h04, 32'h0000_dead);
      // status queue drained earlier, so bit2 is only the held latch
      rd(`OFS_STATUS, 32'h0000_0306, 32'h0000_ff06);
      rd(8'h00, 32'h0000_0011, ALL);
      rd(8'h3c, 32'h0000_0022, ALL);
      rd(8'h20, 32'h0000_0033, ALL);
      rd(8'h10, `WORD_ZERO, ALL);
      rd(`OFS_STATUS, 32'h0000_0002, 32'h0000_ff06);
      rd(`OFS_STATUS, `WORD_ZERO, 32'h0000_ff02);
   endtask : s_rx_data

   task automatic s_tx_data();
      host_model_i.hostWrite(8'h40, 32'h0000_0d01);
      host_model_i.hostWrite(8'h7c, 32'h0000_0d02);
      host_model_i.hostWrite(8'h40, 32'h0000_0d03);
      check_word(txDataOut, 32'h0000_0d01);
      rd(`OFS_STATUS, 32'h0002_0001, SMASK);
      host_model_i.hostWrite(`OFS_STATUS, 32'h00ff_ff0e);
      rd(`OFS_STATUS, 32'h0002_0001, SMASK);
      host_model_i.hostWrite(`OFS_STATUS, 32'h0000_0001);
      rd(`OFS_STATUS, 32'h0002_0000, SMASK);
      @(negedge clock);
      txDataTake = 1'b1;
      @(negedge clock);
      check_word(txDataOut, 32'h0000_0d02);
      @(negedge clock);
      txDataTake = 1'b0;
      check_flag(txDataValid, 1'b0);
      rd(`OFS_STATUS, `WORD_ZERO, 32'h00ff_0008);
      rd(`OFS_STATUS, 32'h0000_0008, 32'h00ff_0008);
      rd(8'h40, `WORD_ZERO, ALL);
      host_model_i.hostWrite(8'h60, 32'h0000_0d04);
      // flush strobe acts one edge after the control write is taken
      host_model_i.hostWrite(`OFS_CONTROL, 32'h0000_0001);
      @(negedge clock);
      check_flag(txDataValid, 1'b0);
      rd(`OFS_CONTROL, `WORD_ZERO, ALL);
      // a self-clearing flush must not swallow the next word
      host_model_i.hostWrite(8'h40, 32'h0000_0d05);
      check_word(txDataOut, 32'h0000_0d05);
   endtask : s_tx_data

   task automatic s_soft();
      host_model_i.hostWrite(`OFS_CONFIG, 32'h0000_a55a);
      host_model_i.hostWrite(8'h44, 32'h0000_0e01);
      check_word({16'h0000, cfgPlain, cfgKept}, 32'h0000_a55a);
      @(negedge clock);
      softReset = 1'b1;
      @(negedge clock);
      softReset = 1'b0;
      check_word({16'h0000, cfgPlain, cfgKept}, 32'h0000_005a);
      check_flag(txDataValid, 1'b0);
      check_flag(rxDataReady && rxStatReady && txStatReady, 1'b1);
      rd(`OFS_CONFIG, 32'h0000_005a, 32'h0000_ffff);
      rd(`OFS_STATUS, 32'h0000_0008, SMASK);
   endtask : s_soft

   task automatic end_of_test();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test

   // hang guard, far beyond the run's length
   initial begin
      repeat (20000) @(posedge clock);
      fail_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      end_of_test();
   end

   initial begin
      clock = 1'b0;
      reset = 1'b1;
      softReset = 1'b0;
      {rxDataPush, rxStatPush, txStatPush, txDataTake} = 4'h0;
      {rxDataIn, rxStatIn, txStatIn} = {3{32'h0000_0000}};
      // tx capacity two so overflow is reached quickly
      txDataLimit = 7'h02;
      rxDataLimit = 7'h00;
      rxStatLimit = 5'h00;
      repeat (4) @(posedge clock);
      @(negedge clock);
      reset = 1'b0;
      s_stat(1'b0);
      s_stat(1'b1);
      s_rx_data();
      s_tx_data();
      s_soft();
      end_of_test();
   end
endmodule : testbench
